// ---- rtl/hsd_synth.sv ----
// Synthesizer end: reference divider, loop dividers, phase detector, output divider
//
// Contract
// - System clock divided by four via two toggles
// - Reference divider clock gated when synthesizer off
// - Loop divider latched while select and strobe low
// - Loop reference divided by 2000 to 1 kHz; here 2.5 kHz from the 20 MHz clock
// - Feedback divided by ratio 6010 to 12000
// - Feedback leads: up pulses low, down high
// - Feedback lags: down pulses low, up high
// - Locked: both high, brief simultaneous low pulse
// - Output dividers latched while select and strobe low
// - Host keeps combined division 5 to 500000
// - Output reference counter clocks divide-by-N counter
// - Two flip-flops halve both counter outputs
// - Band select picks one halved signal only
// - Phase-lock output only while synthesizer enabled
// - Host computes settings including final halving
// - Oscillator supply on while power control low
// - Host shuts synthesizer off when not needed
//
// Chosen here: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ns
`include "hsd_defs.svh"
module hsd_synth (
   input  wire logic ref_clk,
   input  wire logic rst,
   input  wire logic ce,
   hsd_if.dev        bus,
   input  wire logic osc_in,
   output logic      synth_reference_clock,
   output logic      synth_clock_monitor,
   output logic      phase_up_pulse_n,
   output logic      phase_down_pulse_n,
   output logic      phase_lock_out,
   output logic      osc_supply_en
);
   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   logic        osc_s1_q;
   logic        osc_s2_q;
   logic        osc_s3_q;
   logic        div0_q;
   logic        loop_fb_we;
   logic        out_r_we;
   logic        out_n_we;
   logic [13:0] loop_fb_q;
   logic [13:0] out_r_q;
   logic [13:0] out_n_q;
   logic        upper_q;
   logic        lower_q;
   logic        power_on;
   logic        osc_rise;
   logic        ref_tick;
   logic        ref_pulse;
   logic        fb_pulse;
   logic        r_pulse;
   logic        n_pulse;
   logic        n_src;
   logic        up_now;
   logic        dn_now;
   logic        both_now;
   logic        up_d;
   logic        dn_d;
   logic        square;

   // ----------------------------------------
   // Power and strobe decode
   // ----------------------------------------
   // Power control is active low and comes from host flops on this clock
   assign power_on   = ~bus.synth_power_control;
   assign loop_fb_we = ~bus.loop_divider_select_n & ~bus.write_strobe_n;
   assign out_r_we   = ~bus.output_divider_select_n & ~bus.write_strobe_n
                       & (bus.bus_field == hsd_pkg::hsd_field_r);
   assign out_n_we   = ~bus.output_divider_select_n & ~bus.write_strobe_n
                       & (bus.bus_field == hsd_pkg::hsd_field_n);

   // ----------------------------------------
   // Oscillator input synchroniser
   // ----------------------------------------
   // The oscillator is asynchronous, so only the second and third stages are looked at
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         osc_s1_q <= 1'b0;
         osc_s2_q <= 1'b0;
         osc_s3_q <= 1'b0;
      end else if (ce) begin
         osc_s1_q <= osc_in;
         osc_s2_q <= osc_s1_q;
         osc_s3_q <= osc_s2_q;
      end
   end

   // Edges are gated off with the supply so a dead oscillator counts nothing
   assign osc_rise = power_on & osc_s2_q & ~osc_s3_q;

   // ----------------------------------------
   // Reference divider
   // ----------------------------------------
   // Two toggle stages; state freezes while gated so restarts are clean
   assign ref_tick = power_on & div0_q & ~synth_reference_clock;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         div0_q                <= 1'b0;
         synth_reference_clock <= 1'b0;
         synth_clock_monitor   <= 1'b0;
      end else if (ce) begin
         if (power_on) begin
            div0_q <= ~div0_q;
            if (div0_q) begin
               synth_reference_clock <= ~synth_reference_clock;
            end
         end
         synth_clock_monitor <= synth_reference_clock;
      end
   end

   // ----------------------------------------
   // Divider value latches
   // ----------------------------------------
   // Values follow the bus for as long as select and strobe stay low
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         loop_fb_q <= `HSD_FB_RESET;
         out_r_q   <= `HSD_R_RESET;
         out_n_q   <= `HSD_N_RESET;
      end else if (ce) begin
         if (loop_fb_we) begin
            loop_fb_q <= bus.bus_data;
         end
         if (out_r_we) begin
            out_r_q <= bus.bus_data;
         end
         if (out_n_we) begin
            out_n_q <= bus.bus_data;
         end
      end
   end

   // ----------------------------------------
   // Loop synthesizer counters
   // ----------------------------------------
   // Reference counter: fixed ratio gives the comparison rate
   hsd_divider u_loop_ref (
      .ref_clk (ref_clk),
      .rst     (rst),
      .ce      (ce),
      .tick    (ref_tick),
      .ratio   (`HSD_LOOP_REF_DIV),
      .pulse   (ref_pulse)
   );

   // Feedback counter: host keeps the ratio in its legal span
   hsd_divider u_loop_fb (
      .ref_clk (ref_clk),
      .rst     (rst),
      .ce      (ce),
      .tick    (osc_rise),
      .ratio   (loop_fb_q),
      .pulse   (fb_pulse)
   );

   // ----------------------------------------
   // Phase detector
   // ----------------------------------------
   // Up and down are held as active-low flops; once both are low for a
   // cycle they clear together. A new edge in the clearing cycle wins.
   assign up_now   = ~phase_up_pulse_n;
   assign dn_now   = ~phase_down_pulse_n;
   assign both_now = up_now & dn_now;
   assign up_d     = fb_pulse | (up_now & ~both_now);
   assign dn_d     = ref_pulse | (dn_now & ~both_now);

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         phase_up_pulse_n   <= 1'b1;
         phase_down_pulse_n <= 1'b1;
      end else if (ce) begin
         phase_up_pulse_n   <= ~up_d;
         phase_down_pulse_n <= ~dn_d;
      end
   end

   // ----------------------------------------
   // Output synthesizer
   // ----------------------------------------
   // Reference counter runs straight off the oscillator
   hsd_divider u_out_r (
      .ref_clk (ref_clk),
      .rst     (rst),
      .ce      (ce),
      .tick    (osc_rise),
      .ratio   (out_r_q),
      .pulse   (r_pulse)
   );

   // Divide-by-N counter is advanced by the reference counter output
   hsd_divider u_out_n (
      .ref_clk (ref_clk),
      .rst     (rst),
      .ce      (ce),
      .tick    (r_pulse),
      .ratio   (out_n_q),
      .pulse   (n_pulse)
   );

   // N of zero bypasses the second counter, as used on the lower band
   assign n_src = (out_n_q == 14'h0000) ? r_pulse : n_pulse;

   // ----------------------------------------
   // Output switching
   // ----------------------------------------
   // Halving stages give a true square wave whatever the counter duty
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         upper_q <= 1'b0;
         lower_q <= 1'b0;
      end else if (ce) begin
         if (r_pulse) begin
            upper_q <= ~upper_q;
         end
         if (n_src) begin
            lower_q <= ~lower_q;
         end
      end
   end

   // Band select high picks the upper band
   assign square = bus.synth_band_select ? upper_q : lower_q;

   // Output is cut and the supply dropped as soon as power goes off
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         phase_lock_out <= 1'b0;
         osc_supply_en  <= 1'b0;
      end else if (ce) begin
         phase_lock_out <= power_on & square;
         osc_supply_en  <= power_on;
      end
   end
endmodule // hsd_synth

// ---- rtl/hsd_defs.svh ----
// Offsets, field positions, reset values and timing counts of the synthesizer control
`ifndef HSD_DEFS_SVH
`define HSD_DEFS_SVH
// ----------------------------------------
// Host register word indices (Avalon-MM)
// ----------------------------------------
`define HSD_ADDR_CTRL    3'h0
`define HSD_ADDR_LOOP_FB 3'h1
`define HSD_ADDR_OUT_R   3'h2
`define HSD_ADDR_OUT_N   3'h3
`define HSD_ADDR_STATUS  3'h4
// ----------------------------------------
// Field positions
// ----------------------------------------
`define HSD_CTRL_AC      0
`define HSD_CTRL_EXT     1
`define HSD_CTRL_BAND    2
`define HSD_STAT_BUSY    0
`define HSD_STAT_REJ     1
`define HSD_STAT_PWR     2
// ----------------------------------------
// Divider values, reset values and limits
// ----------------------------------------
`define HSD_LOOP_REF_DIV 14'h07d0
`define HSD_FB_RESET     14'h2710
`define HSD_R_RESET      14'h0032
`define HSD_N_RESET      14'h0064
`define HSD_FB_MIN       14'h177a
`define HSD_FB_MAX       14'h2ee0
`define HSD_R_MIN        14'h0005
`define HSD_R_MAX        14'h01f4
`define HSD_N_MAX        14'h03e8
// ----------------------------------------
// Timing
// ----------------------------------------
`define HSD_CLK_MHZ      20
`define HSD_STROBE_NS    100
`define HSD_STROBE_CYC   ((`HSD_STROBE_NS * `HSD_CLK_MHZ + 999) / 1000)
`endif

// ---- rtl/hsd_pkg.sv ----
// Types shared by both ends of the synthesizer control
package hsd_pkg;
   // ----------------------------------------
   // Control bus transfer states
   // ----------------------------------------
   typedef enum logic [3:0] {
      hsd_st_idle   = 4'h1,
      hsd_st_setup  = 4'h2,
      hsd_st_strobe = 4'h4,
      hsd_st_hold   = 4'h8
   } hsd_bus_state_t;
   // Field picked within the output divider
   typedef enum logic {
      hsd_field_r = 1'b0,
      hsd_field_n = 1'b1
   } hsd_field_t;
endpackage

// ---- rtl/hsd_if.sv ----
// Control bus and power/band lines between host and synthesizer
`timescale 1ns/1ns
interface hsd_if;
   logic [13:0]       bus_data;
   hsd_pkg::hsd_field_t bus_field;
   logic              loop_divider_select_n;
   logic              output_divider_select_n;
   logic              write_strobe_n;
   logic              synth_power_control;
   logic              synth_band_select;
   modport host (
      output bus_data,
      output bus_field,
      output loop_divider_select_n,
      output output_divider_select_n,
      output write_strobe_n,
      output synth_power_control,
      output synth_band_select
   );
   modport dev (
      input bus_data,
      input bus_field,
      input loop_divider_select_n,
      input output_divider_select_n,
      input write_strobe_n,
      input synth_power_control,
      input synth_band_select
   );
endinterface

// ---- rtl/hsd_divider.sv ----
// Programmable divide-by-n counter advanced by input ticks
`timescale 1ns/1ns
module hsd_divider (
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic        ce,
   input  wire logic        tick,
   input  wire logic [13:0] ratio,
   output logic             pulse
);
   logic [13:0] cnt_q;
   logic [13:0] cnt_inc;
   logic        wrap;

   // Ratio 0 or 1 passes every tick
   assign cnt_inc = cnt_q + 14'h0001;
   assign wrap    = (cnt_inc >= ratio);

   // One pulse per ratio ticks, a cycle after the last tick
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cnt_q <= 14'h0000;
         pulse <= 1'b0;
      end else if (ce) begin
         pulse <= tick & wrap;
         if (tick) begin
            cnt_q <= wrap ? 14'h0000 : cnt_inc;
         end
      end
   end
endmodule // hsd_divider

// ---- rtl/hsd_host.sv ----
// Host end: Avalon-MM registers and control bus writer for the synthesizer
`timescale 1ns/1ns
`include "hsd_defs.svh"
module hsd_host (
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic        ce,
   input  wire logic [2:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   hsd_if.host              bus
);
   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   hsd_pkg::hsd_bus_state_t state_q;
   logic [2:0]  ctrl_q;
   logic [13:0] fb_q;
   logic [13:0] r_q;
   logic [13:0] n_q;
   logic        rej_q;
   logic        start_q;
   logic        st_loop_q;
   logic [1:0]  cnt_q;
   logic        idle;
   logic        req;
   logic        wr;
   logic [13:0] wd;
   logic        fb_ok;
   logic        r_ok;
   logic        n_ok;
   logic        go_fb;
   logic        go_r;
   logic        go_n;
   logic        bad;
   logic [31:0] rdata;
   logic        strobe_done;

   // ----------------------------------------
   // Request decode and range checks
   // ----------------------------------------
   // A request is only taken while no control bus transfer is pending
   assign idle  = (state_q == hsd_pkg::hsd_st_idle) & ~start_q;
   assign req   = (avs_read | avs_write) & avs_waitrequest & idle;
   assign wr    = req & avs_write;
   assign wd    = avs_writedata[13:0];
   assign fb_ok = (avs_writedata[31:14] == 18'h00000)
                  & (wd >= `HSD_FB_MIN) & (wd <= `HSD_FB_MAX);
   assign r_ok  = (avs_writedata[31:14] == 18'h00000)
                  & (wd >= `HSD_R_MIN) & (wd <= `HSD_R_MAX);
   assign n_ok  = (avs_writedata[31:14] == 18'h00000) & (wd <= `HSD_N_MAX);
   assign go_fb = wr & (avs_address == `HSD_ADDR_LOOP_FB) & fb_ok;
   assign go_r  = wr & (avs_address == `HSD_ADDR_OUT_R) & r_ok;
   assign go_n  = wr & (avs_address == `HSD_ADDR_OUT_N) & n_ok;
   assign bad   = wr & (((avs_address == `HSD_ADDR_LOOP_FB) & ~fb_ok)
                  | ((avs_address == `HSD_ADDR_OUT_R) & ~r_ok)
                  | ((avs_address == `HSD_ADDR_OUT_N) & ~n_ok));
   assign strobe_done = (cnt_q == 2'(`HSD_STROBE_CYC - 1));

   // Read mux; unmapped words read zero
   assign rdata =
      (avs_address == `HSD_ADDR_CTRL)    ? {29'h00000000, ctrl_q} :
      (avs_address == `HSD_ADDR_LOOP_FB) ? {18'h00000, fb_q} :
      (avs_address == `HSD_ADDR_OUT_R)   ? {18'h00000, r_q} :
      (avs_address == `HSD_ADDR_OUT_N)   ? {18'h00000, n_q} :
      (avs_address == `HSD_ADDR_STATUS)  ?
         {29'h00000000, ~bus.synth_power_control, rej_q, 1'b0} : 32'h00000000;

   // ----------------------------------------
   // Avalon-MM slave registers
   // ----------------------------------------
   // Waitrequest drops for exactly one cycle per taken request
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h00000000;
         ctrl_q          <= 3'h0;
         fb_q            <= `HSD_FB_RESET;
         r_q             <= `HSD_R_RESET;
         n_q             <= `HSD_N_RESET;
         rej_q           <= 1'b0;
      end else if (ce) begin
         avs_waitrequest <= ~req;
         avs_readdata    <= req ? rdata : 32'h00000000;
         if (wr & (avs_address == `HSD_ADDR_CTRL)) begin
            ctrl_q <= avs_writedata[2:0];
         end
         if (go_fb) begin
            fb_q <= wd;
         end
         if (go_r) begin
            r_q <= wd;
         end
         if (go_n) begin
            n_q <= wd;
         end
         // Out-of-range values are refused and flagged; set beats clear
         if (bad) begin
            rej_q <= 1'b1;
         end else if (wr & (avs_address == `HSD_ADDR_STATUS)
                      & avs_writedata[`HSD_STAT_REJ]) begin
            rej_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Power and band lines
   // ----------------------------------------
   // Off when an external lock is used or no ac function runs
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         bus.synth_power_control <= 1'b1;
         bus.synth_band_select   <= 1'b0;
      end else if (ce) begin
         bus.synth_power_control <= ~(ctrl_q[`HSD_CTRL_AC]
                                      & ~ctrl_q[`HSD_CTRL_EXT]);
         bus.synth_band_select   <= ctrl_q[`HSD_CTRL_BAND];
      end
   end

   // ----------------------------------------
   // Control bus writer
   // ----------------------------------------
   // Data and select settle a cycle before the strobe and stay a cycle after
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_q                     <= hsd_pkg::hsd_st_idle;
         start_q                     <= 1'b0;
         st_loop_q                   <= 1'b0;
         cnt_q                       <= 2'h0;
         bus.bus_data                <= 14'h0000;
         bus.bus_field               <= hsd_pkg::hsd_field_r;
         bus.loop_divider_select_n   <= 1'b1;
         bus.output_divider_select_n <= 1'b1;
         bus.write_strobe_n          <= 1'b1;
      end else if (ce) begin
         start_q <= go_fb | go_r | go_n;
         if (go_fb | go_r | go_n) begin
            st_loop_q     <= go_fb;
            bus.bus_data  <= wd;
            bus.bus_field <= go_n ? hsd_pkg::hsd_field_n : hsd_pkg::hsd_field_r;
         end
         case (state_q)
            hsd_pkg::hsd_st_idle: begin
               if (start_q) begin
                  bus.loop_divider_select_n   <= ~st_loop_q;
                  bus.output_divider_select_n <= st_loop_q;
                  state_q                     <= hsd_pkg::hsd_st_setup;
               end
            end
            hsd_pkg::hsd_st_setup: begin
               bus.write_strobe_n <= 1'b0;
               cnt_q              <= 2'h0;
               state_q            <= hsd_pkg::hsd_st_strobe;
            end
            hsd_pkg::hsd_st_strobe: begin
               cnt_q <= cnt_q + 2'h1;
               if (strobe_done) begin
                  bus.write_strobe_n <= 1'b1;
                  state_q            <= hsd_pkg::hsd_st_hold;
               end
            end
            hsd_pkg::hsd_st_hold: begin
               bus.loop_divider_select_n   <= 1'b1;
               bus.output_divider_select_n <= 1'b1;
               state_q                     <= hsd_pkg::hsd_st_idle;
            end
            default: begin
               state_q <= hsd_pkg::hsd_st_idle;
            end
         endcase
      end
   end
endmodule // hsd_host

// ---- verif/hsd_asserts.sv ----
// Concurrent checks on the control bus and the synthesizer outputs
`timescale 1ns/1ns
module hsd_asserts (
   input wire logic        ref_clk,
   input wire logic        rst,
   input wire logic [13:0] bus_data,
   input wire logic        loop_divider_select_n,
   input wire logic        output_divider_select_n,
   input wire logic        write_strobe_n,
   input wire logic        synth_power_control,
   input wire logic        synth_reference_clock,
   input wire logic        phase_up_pulse_n,
   input wire logic        phase_down_pulse_n,
   input wire logic        phase_lock_out,
   input wire logic        osc_supply_en
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // ----------------------------------------
   // Control bus transfers
   // ----------------------------------------
   // Either select counts as set-up ahead of the strobe
   wire any_sel = !loop_divider_select_n || !output_divider_select_n;
   sel_excl_a: assert property (loop_divider_select_n || output_divider_select_n)
      else $error("both divider selects low");
   strobe_setup_a: assert property ($fell(write_strobe_n) |-> $past(any_sel) && $stable(bus_data))
      else $error("strobe without settled select and data");
   strobe_width_a: assert property ($fell(write_strobe_n) |=> !write_strobe_n ##1 write_strobe_n)
      else $error("strobe not two cycles wide");
   // ----------------------------------------
   // Reference, supply and output gating
   // ----------------------------------------
   // Disabled while off, since gating may freeze the divider mid-period
   ref_div_a: assert property (disable iff (rst || synth_power_control)
      $rose(synth_reference_clock) |=> synth_reference_clock ##1 !synth_reference_clock [*2]
      ##1 synth_reference_clock) else $error("reference not clock divided by four");
   ref_gate_a: assert property (synth_power_control [*4] |-> $stable(synth_reference_clock))
      else $error("reference runs while off");
   supply_a: assert property (osc_supply_en == !$past(synth_power_control))
      else $error("supply enable wrong");
   lock_off_a: assert property (synth_power_control [*3] |-> !phase_lock_out)
      else $error("output live while off");
   both_low_a: assert property (!phase_up_pulse_n && !phase_down_pulse_n |=>
      phase_up_pulse_n || phase_down_pulse_n) else $error("both phase outputs held low");
   reset_off_a: assert property ($fell(rst) |-> synth_power_control && !phase_lock_out)
      else $error("not off after reset");
   cover property ($fell(write_strobe_n));
   cover property ($fell(phase_down_pulse_n));
   cover property ($rose(phase_lock_out));
endmodule // hsd_asserts

// ---- verif/hsd_tb_top.sv ----
// Self-checking bench joining the host and synthesizer ends
`timescale 1ns/1ns
`include "hsd_defs.svh"
module hsd_tb_top;
   logic        ref_clk = 1'b0;
   logic        rst = 1'b1;
   logic        ce = 1'b1;
   logic [2:0]  avs_address = 3'h0;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        osc_in = 1'b0;
   logic        osc_run = 1'b0;
   logic [2:0]  osc_cnt = 3'h0;
   logic [13:0] loop_seen = 14'h0;
   logic [14:0] out_seen = 15'h0;
   logic        synth_reference_clock, synth_clock_monitor, osc_supply_en;
   logic        phase_up_pulse_n, phase_down_pulse_n, phase_lock_out;
   int          failures = 0;
   int          cmp_count = 0;
   hsd_if bus_if();
   hsd_host hsd_host_inst (.ref_clk, .rst, .ce, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_readdata, .avs_waitrequest, .bus(bus_if));
   hsd_synth hsd_synth_inst (.ref_clk, .rst, .ce, .bus(bus_if), .osc_in, .synth_reference_clock,
      .synth_clock_monitor, .phase_up_pulse_n, .phase_down_pulse_n, .phase_lock_out,
      .osc_supply_en);
   hsd_asserts hsd_asserts_inst (.ref_clk, .rst, .bus_data(bus_if.bus_data),
      .loop_divider_select_n(bus_if.loop_divider_select_n),
      .output_divider_select_n(bus_if.output_divider_select_n),
      .write_strobe_n(bus_if.write_strobe_n), .synth_power_control(bus_if.synth_power_control),
      .synth_reference_clock, .phase_up_pulse_n, .phase_down_pulse_n, .phase_lock_out,
      .osc_supply_en);
   // ----------------------------------------
   // Clock, oscillator stand-in, bus snoop
   // ----------------------------------------
   always #25 ref_clk = ~ref_clk;
   // Period of eight clocks: slow enough for the three-stage synchroniser
   always @(posedge ref_clk) begin
      if (osc_run) osc_cnt <= osc_cnt + 3'h1;
      osc_in <= osc_cnt[2];
   end
   // Record what each divider latch was handed
   always @(posedge ref_clk) begin
      if (!bus_if.loop_divider_select_n && !bus_if.write_strobe_n) loop_seen <= bus_if.bus_data;
      if (!bus_if.output_divider_select_n && !bus_if.write_strobe_n)
         out_seen <= {bus_if.bus_field, bus_if.bus_data};
   end
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task chk(input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         failures++;
         $display("unexpected at %0t ns: seen %h expected %h", $time, s, e);
      end
   endtask
   // Request held until waitrequest is sampled low
   task av(input logic w, input logic [2:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge ref_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      do begin
         @(posedge ref_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 100);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (n >= 100) failures++;
   endtask
   task wr(input logic [2:0] a, input logic [31:0] d);
      logic [31:0] q;
      av(1'b1, a, d, q);
   endtask
   task rd_chk(input logic [2:0] a, input logic [31:0] e);
      logic [31:0] q;
      av(1'b0, a, 32'h0, q);
      chk(q, e);
   endtask
   // Rising edges of one chosen output, falls for the active-low phase outputs, over a span of clocks
   task automatic count(input int sel, input int cyc, output int n);
      logic v;
      logic p;
      n = 0;
      p = 1'b1;
      repeat (cyc) begin
         @(posedge ref_clk);
         v = (sel == 0) ? synth_reference_clock : (sel == 1) ? phase_lock_out :
             (sel == 2) ? !phase_down_pulse_n : !phase_up_pulse_n;
         if (v && !p) n++;
         p = v;
      end
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task t_reset;
      chk(phase_lock_out, 1'b0);
      rd_chk(`HSD_ADDR_CTRL, 32'h0);
      rd_chk(`HSD_ADDR_LOOP_FB, 32'd10000);
      rd_chk(`HSD_ADDR_OUT_R, 32'd50);
      rd_chk(`HSD_ADDR_OUT_N, 32'd100);
      wr(3'h7, 32'h5);
      rd_chk(3'h7, 32'h0);
      chk(osc_supply_en, 1'b0);
      $display("test reset done");
   endtask
   task t_loop;
      wr(`HSD_ADDR_LOOP_FB, 32'd6010);
      rd_chk(`HSD_ADDR_LOOP_FB, 32'd6010);
      chk(loop_seen, 14'd6010);
      wr(`HSD_ADDR_LOOP_FB, 32'd12000);
      wr(`HSD_ADDR_LOOP_FB, 32'd12001);
      wr(`HSD_ADDR_LOOP_FB, 32'd6009);
      rd_chk(`HSD_ADDR_STATUS, 32'h2);
      rd_chk(`HSD_ADDR_LOOP_FB, 32'd12000);
      chk(loop_seen, 14'd12000);
      wr(`HSD_ADDR_STATUS, 32'h2);
      wr(`HSD_ADDR_LOOP_FB, 32'd6010);
      $display("test loop divider done");
   endtask
   task t_out;
      wr(`HSD_ADDR_OUT_R, 32'd5);
      rd_chk(`HSD_ADDR_OUT_R, 32'd5);
      chk(out_seen, {1'b0, 14'd5});
      wr(`HSD_ADDR_OUT_N, 32'd1000);
      rd_chk(`HSD_ADDR_OUT_N, 32'd1000);
      chk(out_seen, {1'b1, 14'd1000});
      wr(`HSD_ADDR_OUT_R, 32'd501);
      wr(`HSD_ADDR_OUT_R, 32'd4);
      wr(`HSD_ADDR_OUT_N, 32'd1001);
      rd_chk(`HSD_ADDR_STATUS, 32'h2);
      rd_chk(`HSD_ADDR_OUT_R, 32'd5);
      wr(`HSD_ADDR_STATUS, 32'h2);
      wr(`HSD_ADDR_OUT_N, 32'd2);
      $display("test output divider done");
   endtask
   task t_power;
      int n;
      logic v;
      wr(`HSD_ADDR_CTRL, 32'h1);
      repeat (3) @(posedge ref_clk);
      chk(osc_supply_en, 1'b1);
      rd_chk(`HSD_ADDR_STATUS, 32'h4);
      // 41 samples give 40 intervals, so ten rises whatever the phase
      count(0, 41, n);
      chk(n, 10);
      // Monitor copies the reference one cycle late; both levels are seen
      repeat (4) begin
         v = synth_reference_clock;
         @(posedge ref_clk);
         chk(synth_clock_monitor, v);
      end
      $display("test power done");
   endtask
   // Feedback at 6010 edges lags the 2.5 kHz reference; a lead is out of reach at this rate
   task t_phase;
      int nd;
      int nu;
      osc_run <= 1'b1;
      fork
         count(2, 20000, nd);
         count(3, 20000, nu);
      join
      chk(nu, 0);
      chk(nd >= 1, 1'b1);
      // First feedback wrap lands near 48000 clocks and clears the held down
      count(3, 30000, nu);
      chk(nu, 1);
      $display("test phase done");
   endtask
   task t_band;
      int n;
      wr(`HSD_ADDR_CTRL, 32'h5);
      repeat (100) @(posedge ref_clk);
      count(1, 800, n);
      chk(n >= 9 && n <= 11, 1'b1);
      wr(`HSD_ADDR_CTRL, 32'h1);
      repeat (400) @(posedge ref_clk);
      count(1, 1600, n);
      chk(n >= 9 && n <= 11, 1'b1);
      wr(`HSD_ADDR_CTRL, 32'h3);
      repeat (4) @(posedge ref_clk);
      count(1, 400, n);
      chk(n, 0);
      chk(phase_lock_out, 1'b0);
      $display("test band done");
   endtask
   // ----------------------------------------
   // Sequence, watchdog and verdict
   // ----------------------------------------
   task close_out;
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge ref_clk);
      rst <= 1'b0;
      t_reset;
      t_loop;
      t_out;
      t_power;
      t_phase;
      t_band;
      close_out;
   end
   // Run needs about 53500 clocks
   initial begin
      repeat (80000) @(posedge ref_clk);
      failures++;
      close_out;
   end
endmodule // hsd_tb_top
